// *** shared/btsc_defines.svh ***
// Functional notes
// - Read the addressed file register and skip the next instruction only if the bit is 0.
// - Operands are an 8-bit file address, a 3-bit bit selector and a 1-bit bank flag.
// - A skipped two-word instruction costs two no-operation cycles instead of one.
// - The next PC is one word on when the bit is set, past the skipped one when clear.
// - Flag 0 selects the access bank, flag 1 takes the bank from the bank select register.
// - Extended set, flag 0 and address up to 95 give indexed literal offset addressing.
`ifndef BTSC_DEFINES_SVH
`define BTSC_DEFINES_SVH
`define BTSC_OPCODE 4'hB
`define BTSC_ACCESS_SPLIT 8'h60
`define BTSC_INDEX_MAX 8'h5F
`define BTSC_LO_BANK 4'h0
`define BTSC_HI_BANK 4'hF
`define BTSC_WORD_BYTES 2
`define BTSC_LAST_PHASE 2'h3
`define BTSC_Q_PHASE_NS 5
`define BTSC_CLK_NS 5
`define BTSC_Q_TICKS ((`BTSC_Q_PHASE_NS + `BTSC_CLK_NS - 1) / `BTSC_CLK_NS)
`endif

// *** shared/btsc_pkg.sv ***
package btsc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_NOP1 = 4'h4,
    ST_NOP2 = 4'h8
  } btsc_state_e;
  typedef logic [1:0] btsc_phase_t;
endpackage

// *** core/btsc_exec.sv ***
`timescale 1ns/1ps
`include "btsc_defines.svh"
module btsc_exec
  import btsc_pkg::*;
#(
  parameter int PC_W = 21,
  parameter int ADDR_W = 12,
  parameter int BANK_W = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Instruction from fetch
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [PC_W-1:0] i_pc,
  input wire logic i_next_two_word,
  // Core state
  input wire logic i_ext_enable,
  input wire logic [BANK_W-1:0] i_bank_select_register,
  input wire logic [ADDR_W-1:0] i_index_base,
  // Data memory
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_rd,
  output logic [ADDR_W-1:0] o_mem_addr,
  // Sequencing
  output logic [1:0] o_phase,
  output logic o_busy,
  output logic o_flush,
  output logic o_nop,
  output logic o_skip,
  output logic o_done,
  output logic [PC_W-1:0] o_next_pc,
  output logic o_status_we
);
  localparam int TICK_W = 4;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`BTSC_Q_TICKS - 1);
  localparam logic [PC_W-1:0] WORD = PC_W'(`BTSC_WORD_BYTES);

  btsc_state_e st_q, st_d;
  btsc_phase_t phase_q;
  logic [TICK_W-1:0] tick_q;
  logic [7:0] f_q;
  logic [2:0] sel_q;
  logic acc_q, bit_q, two_q;
  logic [PC_W-1:0] pc_q;

  // Phase divider
  wire tick = (tick_q == TICK_LAST);
  wire at_q1 = tick && (phase_q == 2'h0);
  wire at_q2 = tick && (phase_q == 2'h1);
  wire at_q3 = tick && (phase_q == 2'h2);
  wire at_q4 = tick && (phase_q == `BTSC_LAST_PHASE);

  wire is_op = (i_instr[15:12] == `BTSC_OPCODE);
  wire accept = (st_q == ST_IDLE) && at_q1 && i_instr_valid && is_op;

  wire [7:0] in_f = i_instr[7:0];
  wire [2:0] in_sel = i_instr[11:9];
  wire in_acc = i_instr[8];

  wire indexed = i_ext_enable && !in_acc && (in_f <= `BTSC_INDEX_MAX);
  wire [ADDR_W-1:0] idx_addr = ADDR_W'(i_index_base + ADDR_W'(in_f));
  wire [BANK_W-1:0] acc_bank = (in_f < `BTSC_ACCESS_SPLIT) ? BANK_W'(`BTSC_LO_BANK) :
                                                              BANK_W'(`BTSC_HI_BANK);
  wire [BANK_W-1:0] bank = in_acc ? i_bank_select_register : acc_bank;
  wire [ADDR_W-1:0] dir_addr = ADDR_W'({bank, in_f});
  wire [ADDR_W-1:0] eff_addr = indexed ? idx_addr : dir_addr;

  wire sampled_bit = i_mem_rdata[sel_q];

  wire [PC_W-1:0] pc_one = PC_W'(pc_q + WORD);
  wire [PC_W-1:0] pc_two = PC_W'(pc_q + WORD + WORD);
  wire [PC_W-1:0] pc_three = PC_W'(pc_q + WORD + WORD + WORD);

  wire fin_set = (st_q == ST_EXEC) && at_q4 && bit_q;
  wire fin_nop1 = (st_q == ST_NOP1) && at_q4 && !two_q;
  wire fin_nop2 = (st_q == ST_NOP2) && at_q4;
  wire finish = fin_set || fin_nop1 || fin_nop2;
  wire [PC_W-1:0] fin_pc = fin_set ? pc_one : (fin_nop1 ? pc_two : pc_three);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (accept) begin
          st_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (at_q4) begin
          st_d = bit_q ? ST_IDLE : ST_NOP1;
        end
      end
      ST_NOP1: begin
        if (at_q4) begin
          st_d = two_q ? ST_NOP2 : ST_IDLE;
        end
      end
      ST_NOP2: begin
        if (at_q4) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_q <= '0;
      phase_q <= 2'h0;
      st_q <= ST_IDLE;
    end else begin
      tick_q <= tick ? '0 : TICK_W'(tick_q + 1'b1);
      phase_q <= tick ? btsc_phase_t'(phase_q + 1'b1) : phase_q;
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      f_q <= 8'h00;
      sel_q <= 3'h0;
      acc_q <= 1'b0;
      two_q <= 1'b0;
      pc_q <= '0;
    end else if (accept) begin
      f_q <= in_f;
      sel_q <= in_sel;
      acc_q <= in_acc;
      two_q <= i_next_two_word;
      pc_q <= i_pc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      bit_q <= 1'b1;
    end else if ((st_q == ST_EXEC) && at_q3) begin
      bit_q <= sampled_bit;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_mem_rd <= 1'b0;
      o_mem_addr <= '0;
    end else if (accept) begin
      o_mem_rd <= 1'b1;
      o_mem_addr <= eff_addr;
    end else if (at_q2) begin
      o_mem_rd <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_phase <= 2'h0;
      o_busy <= 1'b0;
      o_flush <= 1'b0;
      o_nop <= 1'b0;
      o_skip <= 1'b0;
      o_done <= 1'b0;
      o_next_pc <= '0;
      o_status_we <= 1'b0;
    end else begin
      o_phase <= tick ? btsc_phase_t'(phase_q + 1'b1) : phase_q;
      o_busy <= (st_d != ST_IDLE);
      o_flush <= (st_q == ST_EXEC) && at_q4 && !bit_q;
      o_nop <= (st_d == ST_NOP1) || (st_d == ST_NOP2);
      o_skip <= ((st_q == ST_EXEC) && at_q4) ? !bit_q : o_skip;
      o_done <= finish;
      o_next_pc <= finish ? fin_pc : o_next_pc;
      o_status_we <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  a_skip_when_clear: assert property (
    ((st_q == ST_EXEC) && at_q4 && !bit_q) |=> (o_flush && o_nop && (st_q == ST_NOP1)))
    else $error("clear bit did not skip");
  a_no_skip_set: assert property (
    fin_set |=> (o_done && !o_flush && !o_nop && !o_skip))
    else $error("set bit skipped");
  a_operand_capture: assert property (
    accept |=> ((f_q == $past(i_instr[7:0])) && (sel_q == $past(i_instr[11:9]))
                && (acc_q == $past(i_instr[8]))))
    else $error("operands not captured");
  a_two_word_nops: assert property (
    ((st_q == ST_NOP1) && at_q4 && two_q) |=> ((st_q == ST_NOP2) && o_nop && !o_done))
    else $error("two-word skip lacks second no-op");
  a_one_word_nop: assert property (
    ((st_q == ST_NOP1) && at_q4 && !two_q) |=> (o_done && !o_nop && !o_busy))
    else $error("one-word skip too long");
  a_read_strobe: assert property (
    accept |=> (o_mem_rd && o_busy) ##1 !o_mem_rd)
    else $error("read strobe not one phase");
  a_pc_after_test: assert property (
    finish |=> (o_next_pc == ($past(fin_set) ? $past(pc_q) + WORD :
                ($past(two_q) ? $past(pc_q) + 3 * WORD : $past(pc_q) + 2 * WORD))))
    else $error("wrong resume address");
  a_status_untouched: assert property (
    (st_q != ST_IDLE) |-> !o_status_we)
    else $error("status written");
  a_bank_select: assert property (
    (accept && in_acc) |=> (o_mem_addr == {$past(i_bank_select_register), $past(in_f)}))
    else $error("banked address wrong");
  a_indexed_mode: assert property (
    (accept && indexed) |=> (o_mem_addr == $past(idx_addr)) ##1 !o_mem_rd)
    else $error("indexed address wrong");
endmodule

// *** verif/test_bit_test_skip_if_clear_exec.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t mismatch", $time); end end
module test_bit_test_skip_if_clear_exec;
  import btsc_pkg::*;
  logic i_clock = 0, i_srst = 1, i_instr_valid = 0, i_next_two_word = 0, i_ext_enable = 0;
  logic [15:0] i_instr = 16'h0000;
  logic [20:0] i_pc = 21'h000000;
  logic [3:0] i_bank_select_register = 4'h0;
  logic [11:0] i_index_base = 12'h000;
  logic [7:0] i_mem_rdata = 8'h00;
  logic o_mem_rd, o_busy, o_flush, o_nop, o_skip, o_done, o_status_we;
  logic [11:0] o_mem_addr;
  logic [1:0] o_phase;
  logic [20:0] o_next_pc;
  int error_cnt = 0;
  int check_count = 0;
  logic [31:0] r;
  always #2.5 i_clock = ~i_clock;
  btsc_exec btsc_exec_inst (.i_clock(i_clock), .i_srst(i_srst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_pc(i_pc), .i_next_two_word(i_next_two_word),
    .i_ext_enable(i_ext_enable), .i_bank_select_register(i_bank_select_register),
    .i_index_base(i_index_base), .i_mem_rdata(i_mem_rdata), .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr), .o_phase(o_phase), .o_busy(o_busy), .o_flush(o_flush),
    .o_nop(o_nop), .o_skip(o_skip), .o_done(o_done), .o_next_pc(o_next_pc),
    .o_status_we(o_status_we));
  // Effective data address
  function automatic logic [11:0] exp_addr(logic [7:0] f, logic a, logic ext, logic [3:0] bank_select_register,
                                           logic [11:0] base);
    if (a) return {bank_select_register, f};
    if (ext && f <= 8'h5F) return base + {4'h0, f};
    return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run(logic [7:0] f, logic [2:0] b, logic a, logic ext, logic two, logic [7:0] d);
    int n, nops, flushes, exp_n;
    logic clr;
    logic [20:0] pc;
    logic [3:0] bank_select_register;
    logic [11:0] base;
    clr = ~d[b];
    n = 0;
    nops = 0;
    flushes = 0;
    pc = 21'($urandom) & 21'h1FFFFE;
    bank_select_register = 4'($urandom);
    base = 12'($urandom);
    exp_n = 3 + (clr ? 4 : 0) + ((clr && two) ? 4 : 0);
    @(posedge i_clock);
    i_instr <= {4'hB, b, a, f};
    i_instr_valid <= 1'b1;
    i_ext_enable <= ext;
    i_next_two_word <= two;
    i_mem_rdata <= d;
    i_pc <= pc;
    i_bank_select_register <= bank_select_register;
    i_index_base <= base;
    do begin @(posedge i_clock); #1; n++; end while (o_busy !== 1'b1 && n < 8);
    `CHK(o_busy, 1'b1)
    `CHK(o_phase, 2'h1)
    `CHK(o_mem_addr, exp_addr(f, a, ext, bank_select_register, base))
    `CHK(o_mem_rd, 1'b1)
    n = 0;
    while (o_done !== 1'b1 && n < 16) begin
      @(posedge i_clock);
      i_instr_valid <= 1'b0;
      #1;
      n++;
      if (o_nop === 1'b1) nops++;
      if (o_flush === 1'b1) flushes++;
      `CHK(o_status_we, 1'b0)
      `CHK(o_mem_rd, 1'b0)
    end
    `CHK(o_busy, 1'b0)
    `CHK(o_phase, 2'h0)
    `CHK(n, exp_n)
    `CHK(nops, exp_n - 3)
    `CHK(flushes, clr ? 1 : 0)
    `CHK(o_skip, clr)
    `CHK(o_next_pc, pc + 21'(2 + (clr ? 2 : 0) + ((clr && two) ? 2 : 0)))
    $display("test done f=%h b=%0d skip=%0d", f, b, clr);
  endtask
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(9));
    repeat (4) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
    `CHK(o_busy, 1'b0)
    run(8'h5F, 3'd0, 1'b0, 1'b1, 1'b0, 8'hFE);
    run(8'h60, 3'd7, 1'b0, 1'b1, 1'b1, 8'h7F);
    run(8'hFF, 3'd7, 1'b1, 1'b0, 1'b1, 8'h80);
    run(8'h00, 3'd3, 1'b0, 1'b0, 1'b1, 8'h08);
    // Other opcodes ignored
    @(posedge i_clock);
    i_instr <= 16'hA000;
    i_instr_valid <= 1'b1;
    repeat (8) @(posedge i_clock);
    #1;
    `CHK(o_busy, 1'b0)
    $display("test done foreign opcode");
    // Reset in the middle of a skip
    @(posedge i_clock);
    i_instr <= 16'hB000;
    i_mem_rdata <= 8'h00;
    i_instr_valid <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_srst <= 1'b1;
    i_instr_valid <= 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    `CHK(o_busy, 1'b0)
    `CHK(o_nop, 1'b0)
    `CHK(o_skip, 1'b0)
    `CHK(o_next_pc, 21'h000000)
    @(posedge i_clock);
    i_srst <= 1'b0;
    $display("test done mid-run reset");
    repeat (40) begin
      r = $urandom;
      run(r[7:0], r[10:8], r[11], r[12], r[13], r[21:14]);
    end
    stop_test();
  end
endmodule
